// ==== design/rtc_pkg.sv ====
// constants for the calendar, trim and watchdog register block
`default_nettype none
package rtc_pkg;
    // ===================================================
    // register offsets
    localparam logic [7:0] RTC_OFS_DAY   = 8'h05;
    localparam logic [7:0] RTC_OFS_MONTH = 8'h06;
    localparam logic [7:0] RTC_OFS_YEAR  = 8'h07;
    localparam logic [7:0] RTC_OFS_TRIM  = 8'h08;
    localparam logic [7:0] RTC_OFS_WDT   = 8'h09;
    // ===================================================
    // field positions
    localparam int RTC_DAY_MSB      = 5;
    localparam int RTC_MONTH_MSB    = 4;
    localparam int RTC_MONTH_UNUSED = 5;
    localparam int RTC_CENT_LO      = 6;
    localparam int RTC_TRIM_OUT     = 7;
    localparam int RTC_TRIM_UNUSED  = 6;
    localparam int RTC_TRIM_POS     = 5;
    localparam int RTC_TRIM_MAG_MSB = 4;
    localparam int RTC_WDT_SRC_HI   = 7;
    localparam int RTC_WDT_MUL_LSB  = 2;
    localparam int RTC_WDT_MUL_MSB  = 6;
    // ===================================================
    // reset values
    localparam logic [5:0] RTC_RST_DAY   = 6'h01;
    localparam logic [4:0] RTC_RST_MONTH = 5'h01;
    localparam logic [1:0] RTC_RST_CENT  = 2'h0;
    localparam logic [7:0] RTC_RST_YEAR  = 8'h00;
    localparam logic [7:0] RTC_RST_TRIM  = 8'h00;
    localparam logic [7:0] RTC_RST_WDT   = 8'h00;
    // ===================================================
    // watchdog tick sources and their period as multiples of the 16 Hz period
    typedef enum logic [2:0] {
        RTC_SRC_16HZ   = 3'b000,
        RTC_SRC_4HZ    = 3'b001,
        RTC_SRC_1HZ    = 3'b010,
        RTC_SRC_QHZ    = 3'b011,
        RTC_SRC_60S    = 3'b100
    } rtc_src_type;
    localparam int RTC_OSC_PER_16HZ = 2048;
    localparam int RTC_MUL_4HZ      = 4;
    localparam int RTC_MUL_1HZ      = 16;
    localparam int RTC_MUL_QHZ      = 64;
    localparam int RTC_MUL_60S      = 960;
endpackage
`default_nettype wire

// ==== design/rtc_regs.sv ====
// calendar, frequency trim and watchdog registers with interrupt pin logic
// Function
// - day register holds six BCD bits; upper two bits are zero
// - month held as BCD 1..12 in bits 4..0; bit 5 reads zero
// - century field in bits 7..6; year 00 leap only in century 00
// - year register holds full eight-bit BCD year 0..99
// - with no interrupt source enabled, interrupt pin follows trim bit 7
// - trim bit 5 picks direction, one positive; bit 6 stays zero
// - trim bits 4..0 hold binary magnitude 0..31
// - watchdog source bits 7,1,0 pick 16, 4, 1, 1/4 or 1/60 Hz
// - watchdog bits 6..2 hold binary multiplier 0..31
// - oscillator fail enable lets a detected failure drive the interrupt
`default_nettype none
module rtc_regs
    import rtc_pkg::*;
#(
    parameter int OSC_PER_16HZ = RTC_OSC_PER_16HZ
) (
    input  wire logic       clock_i,          // 125 MHz clock
    input  wire logic       arst_n_i,         // asynchronous reset, low active
    input  wire logic [7:0] reg_addr_i,       // register address
    input  wire logic [7:0] reg_wdata_i,      // write data
    input  wire logic       reg_wr_i,         // write strobe
    output logic      [7:0] reg_rdata_o,      // read data, one cycle after address
    input  wire logic       osc_tick_i,       // one pulse per 32.768 kHz period
    input  wire logic       osc_fail_i,       // oscillator failure detected
    input  wire logic       osc_fail_irq_en_i,// oscillator fail interrupt enable
    input  wire logic       alarm_flag_i,     // alarm flag set
    input  wire logic       alarm_flag_en_i,  // alarm flag enable
    input  wire logic       wdt_flag_clr_i,   // clears the watchdog flag
    output logic            wdt_flag_o,       // watchdog timeout flag
    output logic            leap_year_o,      // current year is a leap year
    output logic            trim_pos_o,       // trim direction, high positive
    output logic      [4:0] trim_mag_o,       // trim magnitude
    output logic            int_n_o           // interrupt pin, low active
);
    localparam int PW = $clog2(OSC_PER_16HZ * RTC_MUL_60S + 1);

    // refuse a prescaler that cannot count
    if (OSC_PER_16HZ < 1) begin : g_bad_period
        $error("OSC_PER_16HZ must be at least one");
    end

    typedef struct packed {
        logic [5:0]    day;
        logic [1:0]    century;
        logic [4:0]    month;
        logic [7:0]    year;
        logic          trim_out;
        logic          trim_pos;
        logic [4:0]    trim_mag;
        logic [7:0]    wdt;
        logic [PW-1:0] pre;
        logic [4:0]    mul_cnt;
        logic          wdt_flag;
        logic [7:0]    rdata;
    } rtc_state_type;

    rtc_state_type st;
    rtc_state_type next_st;

    // ===================================================
    // helper functions
    function automatic logic [PW-1:0] src_period(input logic [2:0] src);
        logic [PW-1:0] p;
        p = '0;
        unique case (src)
            RTC_SRC_16HZ: p = PW'(OSC_PER_16HZ);
            RTC_SRC_4HZ:  p = PW'(OSC_PER_16HZ * RTC_MUL_4HZ);
            RTC_SRC_1HZ:  p = PW'(OSC_PER_16HZ * RTC_MUL_1HZ);
            RTC_SRC_QHZ:  p = PW'(OSC_PER_16HZ * RTC_MUL_QHZ);
            RTC_SRC_60S:  p = PW'(OSC_PER_16HZ * RTC_MUL_60S);
            default:      p = '0;
        endcase
        return p;
    endfunction

    function automatic logic bcd_div4(input logic [7:0] y);
        logic ev;
        ev = ~y[4];
        return ev ? (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8)
                  : (y[3:0] == 4'h2 || y[3:0] == 4'h6);
    endfunction

    logic [2:0]    wdt_src;
    logic [4:0]    wdt_mul;
    logic [PW-1:0] period;
    logic          wdt_active;
    logic          any_src;

    assign wdt_src    = {st.wdt[RTC_WDT_SRC_HI], st.wdt[1:0]};
    assign wdt_mul    = st.wdt[RTC_WDT_MUL_MSB:RTC_WDT_MUL_LSB];
    assign period     = src_period(wdt_src);
    assign wdt_active = (wdt_mul != 5'h00) && (period != '0);

    // ===================================================
    // next state
    always_comb begin
        next_st = st;
        if (reg_wr_i) begin
            unique case (reg_addr_i)
                RTC_OFS_DAY:   next_st.day = reg_wdata_i[RTC_DAY_MSB:0];
                RTC_OFS_MONTH: begin
                    next_st.month   = reg_wdata_i[RTC_MONTH_MSB:0];
                    next_st.century = reg_wdata_i[7:RTC_CENT_LO];
                end
                RTC_OFS_YEAR:  next_st.year = reg_wdata_i;
                RTC_OFS_TRIM:  begin
                    next_st.trim_out = reg_wdata_i[RTC_TRIM_OUT];
                    next_st.trim_pos = reg_wdata_i[RTC_TRIM_POS];
                    next_st.trim_mag = reg_wdata_i[RTC_TRIM_MAG_MSB:0];
                end
                RTC_OFS_WDT:   next_st.wdt = reg_wdata_i;
                default:       next_st.day = st.day;
            endcase
        end
        // watchdog: prescale oscillator ticks, then count source periods
        if (reg_wr_i && reg_addr_i == RTC_OFS_WDT) begin
            next_st.pre     = '0;
            next_st.mul_cnt = 5'h00;
        end else if (!wdt_active) begin
            next_st.pre     = '0;
            next_st.mul_cnt = 5'h00;
        end else if (osc_tick_i) begin
            if (st.pre == period - PW'(1)) begin
                next_st.pre = '0;
                if (st.mul_cnt == wdt_mul - 5'h01) begin
                    next_st.mul_cnt = 5'h00;
                    next_st.wdt_flag = 1'b1;
                end else begin
                    next_st.mul_cnt = st.mul_cnt + 5'h01;
                end
            end else begin
                next_st.pre = st.pre + PW'(1);
            end
        end
        // a flag that rises in the clear cycle stays set
        if (wdt_flag_clr_i && !(next_st.wdt_flag && !st.wdt_flag)) begin
            next_st.wdt_flag = 1'b0;
        end
        unique case (reg_addr_i)
            RTC_OFS_DAY:   next_st.rdata = {2'h0, st.day};
            RTC_OFS_MONTH: next_st.rdata = {st.century, 1'b0, st.month};
            RTC_OFS_YEAR:  next_st.rdata = st.year;
            RTC_OFS_TRIM:  next_st.rdata = {st.trim_out, 1'b0, st.trim_pos,
                                            st.trim_mag};
            RTC_OFS_WDT:   next_st.rdata = st.wdt;
            default:       next_st.rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st          <= '0;
            st.day      <= RTC_RST_DAY;
            st.month    <= RTC_RST_MONTH;
            st.century  <= RTC_RST_CENT;
            st.year     <= RTC_RST_YEAR;
            st.trim_out <= RTC_RST_TRIM[RTC_TRIM_OUT];
            st.trim_pos <= RTC_RST_TRIM[RTC_TRIM_POS];
            st.trim_mag <= RTC_RST_TRIM[RTC_TRIM_MAG_MSB:0];
            st.wdt      <= RTC_RST_WDT;
        end else begin
            st <= next_st;
        end
    end

    // ===================================================
    // outputs
    assign reg_rdata_o = st.rdata;
    assign wdt_flag_o  = st.wdt_flag;
    assign trim_pos_o  = st.trim_pos;
    assign trim_mag_o  = st.trim_mag;
    assign leap_year_o = (st.year == 8'h00) ? (st.century == 2'b00)
                                            : bcd_div4(st.year);
    assign any_src     = osc_fail_irq_en_i || alarm_flag_en_i || wdt_active;
    assign int_n_o     = !any_src ? st.trim_out
                       : !((osc_fail_irq_en_i && osc_fail_i)
                         || (alarm_flag_en_i && alarm_flag_i) || st.wdt_flag);

    // ===================================================
    // assertions
    AST_DAY_WR: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == RTC_OFS_DAY ##1 reg_addr_i == RTC_OFS_DAY
        |=> reg_rdata_o == {2'h0, $past(reg_wdata_i[5:0], 2)})
        else $error("day register readback wrong");
    AST_MONTH_RD: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        reg_addr_i == RTC_OFS_MONTH |=> reg_rdata_o[5] == 1'b0
            && reg_rdata_o[4:0] == $past(st.month))
        else $error("month readback wrong");
    AST_LEAP00: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        st.year == 8'h00 |-> leap_year_o == (st.century == 2'b00))
        else $error("year 00 leap wrong");
    AST_YEAR_WR: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == RTC_OFS_YEAR |=> st.year == $past(reg_wdata_i))
        else $error("year not stored");
    AST_INT_GPO: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        !osc_fail_irq_en_i && !alarm_flag_en_i && wdt_mul == 5'h00
        |-> int_n_o == st.trim_out)
        else $error("pin does not follow output bit");
    AST_TRIM_DIR: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == RTC_OFS_TRIM
        |=> trim_pos_o == $past(reg_wdata_i[5]) && !st.rdata[6])
        else $error("trim direction wrong");
    AST_TRIM_MAG: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        reg_wr_i && reg_addr_i == RTC_OFS_TRIM |=> trim_mag_o == $past(reg_wdata_i[4:0]))
        else $error("trim magnitude wrong");
    AST_SRC_ILLEGAL: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        wdt_src[2] && wdt_src[1:0] != 2'b00 |=> !$rose(st.wdt_flag))
        else $error("illegal source caused timeout");
    AST_MUL_ZERO: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        wdt_mul == 5'h00 |=> !$rose(st.wdt_flag) && st.pre == '0)
        else $error("zero multiplier ran watchdog");
    AST_OSC_IRQ: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        osc_fail_irq_en_i && osc_fail_i |-> !int_n_o)
        else $error("oscillator fail not signalled");
    AST_WDT_TIMEOUT: assert property (@(posedge clock_i) disable iff (!arst_n_i)
        wdt_active && osc_tick_i && st.pre == period - PW'(1)
        && st.mul_cnt == wdt_mul - 5'h01 && !(reg_wr_i && reg_addr_i == RTC_OFS_WDT)
        |=> st.wdt_flag)
        else $error("timeout not flagged");
endmodule
`default_nettype wire

// ==== bench/rtc_host_model.sv ====
// host side model that reaches the calendar registers over the byte port
`default_nettype none
module rtc_host_model
    import rtc_pkg::*;
(
    input  wire logic       clock_i,     // system clock
    output logic      [7:0] reg_addr_o,  // register address
    output logic      [7:0] reg_wdata_o, // write data
    output logic            reg_wr_o,    // write strobe
    input  wire logic [7:0] reg_rdata_i  // read data
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_addr_o  = 8'h00;
        reg_wdata_o = 8'h00;
        reg_wr_o    = 1'b0;
    end
    // ==================================================
    // bus cycles
    task automatic write_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clock_i);
        reg_addr_o  <= addr;
        reg_wdata_o <= (addr == RTC_OFS_DAY) ? (data & 8'h3F) : data;
        reg_wr_o    <= 1'b1;
        @(posedge clock_i);
        reg_wr_o    <= 1'b0;
        // released data no longer shows the written byte
        reg_wdata_o <= ~data;
    endtask
    task automatic read_reg(input logic [7:0] addr, output logic [7:0] data);
        @(posedge clock_i);
        reg_addr_o <= addr;
        @(posedge clock_i);
        @(posedge clock_i);
        #1;
        data = reg_rdata_i;
    endtask
endmodule
`default_nettype wire

// ==== bench/tb_rtc_regs.sv ====
// self-checking testbench for the calendar, trim and watchdog registers
`default_nettype none
module tb_rtc_regs
    import rtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int OSC = 2;
    logic       clock_i, arst_n_i, wr, tick, ofail, oen, aflag, aen, clr;
    logic       wflag, leap, tpos, int_n;
    logic [7:0] addr, wdata, rdata, d;
    logic [4:0] tmag;
    int         n_fail, checked;
    rtc_host_model host (.clock_i(clock_i), .reg_addr_o(addr), .reg_wdata_o(wdata),
        .reg_wr_o(wr), .reg_rdata_i(rdata));
    rtc_regs #(.OSC_PER_16HZ(OSC)) uut (.clock_i(clock_i), .arst_n_i(arst_n_i),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rdata_o(rdata),
        .osc_tick_i(tick), .osc_fail_i(ofail), .osc_fail_irq_en_i(oen),
        .alarm_flag_i(aflag), .alarm_flag_en_i(aen), .wdt_flag_clr_i(clr),
        .wdt_flag_o(wflag), .leap_year_o(leap), .trim_pos_o(tpos), .trim_mag_o(tmag),
        .int_n_o(int_n));
    // ==================================================
    // helpers
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch at %0t: bit %b expected %b", $time, got, exp);
        end
    endtask
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge clock_i);
            tick <= 1'b1;
            @(posedge clock_i);
            tick <= 1'b0;
        end
        #1;
    endtask
    task automatic inputs(input logic f, input logic fe, input logic a, input logic ae);
        @(posedge clock_i);
        {ofail, oen, aflag, aen} <= {f, fe, a, ae};
        @(posedge clock_i);
        #1;
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #4 clock_i = ~clock_i;
    end
    initial begin
        repeat (100000) @(posedge clock_i);
        n_fail++;
        final_report;
    end
    // ==================================================
    // main sequence
    initial begin
        logic [7:0] wa[6] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A};
        logic [7:0] wd[6] = '{8'h31, 8'hF2, 8'h99, 8'hFF, 8'hFF, 8'h55};
        logic [7:0] we[6] = '{8'h31, 8'hD2, 8'h99, 8'hBF, 8'hFF, 8'h00};
        logic [7:0] ly[7] = '{8'h00, 8'h00, 8'h00, 8'h04, 8'h01, 8'h96, 8'h12};
        logic [1:0] lc[7] = '{2'h0, 2'h1, 2'h3, 2'h1, 2'h0, 2'h2, 2'h0};
        logic       le[7] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
        int         per[5] = '{1, RTC_MUL_4HZ, RTC_MUL_1HZ, RTC_MUL_QHZ, RTC_MUL_60S};
        logic [2:0] c;
        {arst_n_i, tick, ofail, oen, aflag, aen, clr} = 7'h00;
        n_fail = 0;
        checked = 0;
        repeat (5) @(posedge clock_i);
        arst_n_i <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            host.read_reg(wa[i], d);
            chk8(d, (i < 2) ? 8'h01 : 8'h00);
        end
        for (int i = 0; i < 6; i++) host.write_reg(wa[i], wd[i]);
        for (int i = 0; i < 6; i++) begin
            host.read_reg(wa[i], d);
            chk8(d, we[i]);
        end
        chk8({2'h0, tpos, tmag}, 8'h3F);
        chk1(int_n, 1'b1);
        host.write_reg(RTC_OFS_TRIM, 8'h05);
        #1;
        chk8({2'h0, tpos, tmag}, 8'h05);
        chk1(int_n, 1'b0);
        for (int i = 0; i < 7; i++) begin
            host.write_reg(RTC_OFS_MONTH, {lc[i], 6'h01});
            host.write_reg(RTC_OFS_YEAR, ly[i]);
            #1;
            chk1(leap, le[i]);
        end
        host.write_reg(RTC_OFS_TRIM, 8'h80);
        host.write_reg(RTC_OFS_WDT, 8'h00);
        inputs(1'b1, 1'b0, 1'b0, 1'b0);
        chk1(int_n, 1'b1);
        inputs(1'b1, 1'b1, 1'b0, 1'b0);
        chk1(int_n, 1'b0);
        inputs(1'b0, 1'b1, 1'b0, 1'b0);
        chk1(int_n, 1'b1);
        inputs(1'b0, 1'b0, 1'b1, 1'b1);
        chk1(int_n, 1'b0);
        inputs(1'b0, 1'b0, 1'b0, 1'b0);
        for (int k = 0; k < 6; k++) begin
            c = (k < 5) ? k[2:0] : 3'b000;
            host.write_reg(RTC_OFS_WDT, {c[2], (k < 5) ? 5'h01 : 5'h03, c[1:0]});
            @(posedge clock_i);
            clr <= 1'b1;
            @(posedge clock_i);
            clr <= 1'b0;
            ticks(OSC * ((k < 5) ? per[k] : 3) - 1);
            chk1(wflag, 1'b0);
            ticks(1);
            chk1(wflag, 1'b1);
            chk1(int_n, 1'b0);
        end
        host.write_reg(RTC_OFS_WDT, 8'h00);
        @(posedge clock_i);
        clr <= 1'b1;
        @(posedge clock_i);
        clr <= 1'b0;
        ticks(8 * OSC);
        chk1(wflag, 1'b0);
        host.write_reg(RTC_OFS_WDT, 8'h85);
        ticks(8 * OSC);
        chk1(wflag, 1'b0);
        final_report;
    end
endmodule
`default_nettype wire
